/* common/sfs_defs.svh */
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SFS_CTRL_OFF 12'h000
`define SFS_STAT_OFF 12'h004
`define SFS_DATA_OFF 12'h008
`define SFS_BAUD_OFF 12'h00C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SFS_C_TXON 0
`define SFS_C_RXON 1
`define SFS_C_TIE 2
`define SFS_C_TX_DONE_IRQ_MASK 3
`define SFS_C_RIE 4
`define SFS_C_ILIE 5
`define SFS_C_BRK 6
`define SFS_C_WAKE 7
`define SFS_C_LONG 8
`define SFS_CTRL_W 9
`define SFS_CTRL_RST 9'h000

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define SFS_S_TX_HOLD_EMPTY_FLAG 0
`define SFS_S_TC 1
`define SFS_S_RX_FULL_FLAG 2
`define SFS_S_IDLE 3
`define SFS_S_OR 4
`define SFS_S_NF 5
`define SFS_S_FE 6
`define SFS_S_RAF 7

// ----------------------------------------------------------------------------
// Bit timing
// ----------------------------------------------------------------------------
`define SFS_BAUD_RST 16'h0035
`define SFS_OVS_LAST 4'hF
`define SFS_VOTE_A 4'h7
`define SFS_VOTE_B 4'h8
`define SFS_VOTE_C 4'h9

`endif

/* common/sfs_pkg.sv */
package sfs_pkg;

    typedef enum logic [1:0] {
        SFS_RX_IDLE = 2'b00,
        SFS_RX_START = 2'b01,
        SFS_RX_DATA = 2'b10,
        SFS_RX_STOP = 2'b11
    } sfs_rx_state_t;

endpackage

/* design/sfs_sci.sv */
`include "sfs_defs.svh"

module sfs_sci #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd_out,
    output logic txd_oe,
    output logic sci_irq
);

    initial begin
        if (ADDR_W < 4) begin
            $error("sfs_sci: ADDR_W must be at least 4");
        end
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic sfs_at(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        sfs_at = (a == ADDR_W'(off));
    endfunction

    function automatic logic sfs_major(input logic [2:0] v);
        sfs_major = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    logic [`SFS_CTRL_W-1:0] ctrl;
    logic [15:0] baud_div;
    logic [15:0] baud_cnt;
    logic tick;
    logic tx_hold_empty_flag, tc, rx_full_flag, idle, ovr, nf, fe;
    logic [7:0] rx_hold_reg;
    sfs_pkg::sfs_rx_state_t rx_state;

    wire logic tx_on = ctrl[`SFS_C_TXON];
    wire logic rx_on = ctrl[`SFS_C_RXON];
    wire logic [7:0] stat = {rx_state != sfs_pkg::SFS_RX_IDLE, fe, nf, ovr, idle, rx_full_flag, tc, tx_hold_empty_flag};
    wire logic mapped = sfs_at(paddr, `SFS_CTRL_OFF) | sfs_at(paddr, `SFS_STAT_OFF)
                      | sfs_at(paddr, `SFS_DATA_OFF) | sfs_at(paddr, `SFS_BAUD_OFF);
    wire logic done = psel & penable & pready;
    wire logic wr_ok = done & pwrite & ~pslverr;
    wire logic wr_ctrl = wr_ok & sfs_at(paddr, `SFS_CTRL_OFF);
    wire logic wr_data = wr_ok & sfs_at(paddr, `SFS_DATA_OFF);
    wire logic rd_stat = done & ~pwrite & sfs_at(paddr, `SFS_STAT_OFF);
    wire logic rd_data = done & ~pwrite & sfs_at(paddr, `SFS_DATA_OFF);
    wire logic tx_rise = wr_ctrl & pwdata[`SFS_C_TXON] & ~tx_on;
    wire logic tx_fall = wr_ctrl & ~pwdata[`SFS_C_TXON] & tx_on;

    // ------------------------------------------------------------------------
    // APB slave: setup cycle prepares the answer, access ends in one cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            if (psel && !penable) begin
                pready <= 1'b1;
                pslverr <= ~mapped;
                prdata <= 32'h00000000;
                if (!pwrite) begin
                    unique case (1'b1)
                        sfs_at(paddr, `SFS_CTRL_OFF): prdata <= 32'(ctrl);
                        sfs_at(paddr, `SFS_STAT_OFF): prdata <= 32'(stat);
                        sfs_at(paddr, `SFS_DATA_OFF): prdata <= 32'(rx_hold_reg);
                        sfs_at(paddr, `SFS_BAUD_OFF): prdata <= 32'(baud_div);
                        default: prdata <= 32'h00000000;
                    endcase
                end
            end else if (done) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control and rate registers
    // ------------------------------------------------------------------------
    logic wake_exit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SFS_CTRL_RST;
            baud_div <= `SFS_BAUD_RST;
        end else if (ce) begin
            if (wake_exit) begin
                ctrl[`SFS_C_WAKE] <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl <= pwdata[`SFS_CTRL_W-1:0];
            end
            if (wr_ok && sfs_at(paddr, `SFS_BAUD_OFF)) begin
                baud_div <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Oversample tick: sixteen per bit time
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= (baud_cnt >= baud_div);
            baud_cnt <= (baud_cnt >= baud_div) ? 16'h0000 : baud_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Transmitter: one holding word in front of the shifter
    // ------------------------------------------------------------------------
    logic [7:0] tx_hold_reg;
    logic hold_valid, tx_busy;
    logic [10:0] tx_shift;
    logic [3:0] tx_phase, tx_bits;
    wire logic [3:0] tx_last = ctrl[`SFS_C_LONG] ? 4'hA : 4'h9;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Reset is the only path that cuts a character short
            tx_hold_empty_flag <= 1'b1;
            tc <= 1'b1;
            hold_valid <= 1'b0;
            tx_hold_reg <= 8'h00;
            tx_busy <= 1'b0;
            tx_shift <= 11'h7FF;
            tx_phase <= 4'h0;
            tx_bits <= 4'h0;
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
        end else if (ce) begin
            txd_out <= tx_busy ? tx_shift[0] : ~(ctrl[`SFS_C_BRK] & tx_on);
            if (tick) begin
                if (tx_busy) begin
                    tx_phase <= tx_phase + 4'h1;
                    if (tx_phase == `SFS_OVS_LAST) begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        tx_bits <= tx_bits + 4'h1;
                        if (tx_bits == tx_last) begin
                            tx_busy <= 1'b0;
                            if (!hold_valid) begin
                                tc <= 1'b1;
                            end
                            if (!tx_on) begin
                                tx_hold_empty_flag <= 1'b1;
                                tc <= 1'b1;
                            end
                        end
                    end
                end else if (tx_on && hold_valid) begin
                    // Ninth data bit in long frames is sent as a one
                    tx_shift <= {2'b11, tx_hold_reg, 1'b0};
                    tx_busy <= 1'b1;
                    tx_phase <= 4'h0;
                    tx_bits <= 4'h0;
                    hold_valid <= 1'b0;
                    tx_hold_empty_flag <= 1'b1;
                    txd_oe <= 1'b1;
                end else begin
                    txd_oe <= tx_on;
                end
            end
            if (tx_rise) begin
                tx_hold_empty_flag <= 1'b1;
                tc <= 1'b1;
            end
            if (tx_fall) begin
                // Shifter keeps running; only the queue is dropped
                hold_valid <= 1'b0;
                if (!tx_busy) begin
                    tx_hold_empty_flag <= 1'b1;
                    tc <= 1'b1;
                end
            end
            if (wr_data && tx_on) begin
                tx_hold_reg <= pwdata[7:0];
                hold_valid <= 1'b1;
                tx_hold_empty_flag <= 1'b0;
                tc <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Receiver with majority vote, idle detect and flag clearing
    // ------------------------------------------------------------------------
    logic [3:0] rx_phase, rx_bits;
    logic [8:0] rx_shift;
    logic [2:0] votes;
    logic rx_noise, line_busy;
    logic [7:0] ones_cnt;
    logic [4:0] arm;
    wire logic [3:0] rx_last = ctrl[`SFS_C_LONG] ? 4'h8 : 4'h7;
    wire logic [7:0] idle_ticks = ctrl[`SFS_C_LONG] ? 8'hB0 : 8'hA0;
    wire logic decide = tick & (rx_phase == `SFS_VOTE_C);
    wire logic [2:0] votes_now = {rxd, votes[1:0]};
    wire logic bit_val = sfs_major(votes_now);
    wire logic bit_noisy = (votes_now != 3'b000) & (votes_now != 3'b111);
    wire logic quiet = ctrl[`SFS_C_WAKE];
    assign wake_exit = tick & rx_on & rxd & line_busy & (ones_cnt >= idle_ticks);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= sfs_pkg::SFS_RX_IDLE;
            rx_phase <= 4'h0;
            rx_bits <= 4'h0;
            rx_shift <= 9'h000;
            votes <= 3'h0;
            rx_noise <= 1'b0;
        end else if (ce) begin
            if (!rx_on) begin
                rx_state <= sfs_pkg::SFS_RX_IDLE;
            end else if (tick) begin
                rx_phase <= (rx_phase == `SFS_OVS_LAST) ? 4'h0 : rx_phase + 4'h1;
                if (rx_phase == `SFS_VOTE_A || rx_phase == `SFS_VOTE_B) begin
                    votes <= {votes[1:0], rxd};
                end
                unique case (rx_state)
                    sfs_pkg::SFS_RX_IDLE: begin
                        if (!rxd) begin
                            rx_state <= sfs_pkg::SFS_RX_START;
                            rx_phase <= 4'h1;
                            rx_noise <= 1'b0;
                        end
                    end
                    sfs_pkg::SFS_RX_START: begin
                        if (decide) begin
                            rx_noise <= bit_noisy;
                            rx_bits <= 4'h0;
                            rx_state <= bit_val ? sfs_pkg::SFS_RX_IDLE : sfs_pkg::SFS_RX_DATA;
                        end
                    end
                    sfs_pkg::SFS_RX_DATA: begin
                        if (decide) begin
                            rx_noise <= rx_noise | bit_noisy;
                            rx_shift <= {bit_val, rx_shift[8:1]};
                            rx_bits <= rx_bits + 4'h1;
                            if (rx_bits == rx_last) begin
                                rx_state <= sfs_pkg::SFS_RX_STOP;
                            end
                        end
                    end
                    sfs_pkg::SFS_RX_STOP: begin
                        if (decide) begin
                            rx_state <= sfs_pkg::SFS_RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Character in the stop slot, after the vote
    wire logic rx_xfer = rx_on & decide & (rx_state == sfs_pkg::SFS_RX_STOP) & ~quiet;
    wire logic [7:0] rx_char = ctrl[`SFS_C_LONG] ? rx_shift[7:0] : rx_shift[8:1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_flag <= 1'b0;
            idle <= 1'b0;
            ovr <= 1'b0;
            nf <= 1'b0;
            fe <= 1'b0;
            rx_hold_reg <= 8'h00;
            arm <= 5'h00;
            line_busy <= 1'b0;
            ones_cnt <= 8'h00;
        end else if (ce) begin
            if (rd_stat) begin
                arm <= {prdata[`SFS_S_FE], prdata[`SFS_S_NF], prdata[`SFS_S_OR],
                        prdata[`SFS_S_IDLE], prdata[`SFS_S_RX_FULL_FLAG]};
            end
            if (rd_data) begin
                // Clears first so a same-cycle set below wins
                rx_full_flag <= rx_full_flag & ~arm[0];
                idle <= idle & ~arm[1];
                ovr <= ovr & ~arm[2];
                nf <= nf & ~arm[3];
                fe <= fe & ~arm[4];
                arm <= 5'h00;
            end
            if (tick && rx_on) begin
                if (!rxd) begin
                    ones_cnt <= 8'h00;
                    line_busy <= 1'b1;
                end else if (ones_cnt < idle_ticks) begin
                    ones_cnt <= ones_cnt + 8'h01;
                end
            end
            if (wake_exit) begin
                line_busy <= 1'b0;
                if (!quiet) begin
                    idle <= 1'b1;
                end
            end
            if (rx_xfer) begin
                if (rx_full_flag) begin
                    ovr <= 1'b1;
                end else begin
                    rx_hold_reg <= rx_char;
                    rx_full_flag <= 1'b1;
                    nf <= rx_noise | bit_noisy;
                    fe <= ~bit_val;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt request; noise and framing never take part
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sci_irq <= 1'b0;
        end else if (ce) begin
            sci_irq <= (ctrl[`SFS_C_TIE] & tx_hold_empty_flag)
                     | (ctrl[`SFS_C_TX_DONE_IRQ_MASK] & tc)
                     | (ctrl[`SFS_C_RIE] & (rx_full_flag | ovr))
                     | (ctrl[`SFS_C_ILIE] & idle);
        end
    end

endmodule

/* bench/sfs_sci_monitor.sv */
`include "sfs_defs.svh"

module sfs_sci_monitor #(
    parameter int ADDR_W = 12
) (
    input logic pclk,
    input logic presetn,
    input logic ce,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic rxd,
    input logic txd_out,
    input logic txd_oe,
    input logic sci_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] ctrl_m;
    logic [15:0] baud_m;
    logic touched;
    logic txd_q;
    int frm_cnt;
    wire logic acc = ce && psel && penable && pready;
    wire logic stat_rd = acc && !pwrite && paddr == `SFS_STAT_OFF;

    // Shadow of the writes, so the checker knows masks and bit length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_m <= `SFS_CTRL_RST;
            baud_m <= `SFS_BAUD_RST;
            touched <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == `SFS_CTRL_OFF) ctrl_m <= pwdata[8:0];
            if (acc && pwrite && paddr == `SFS_BAUD_OFF) baud_m <= pwdata[15:0];
            if ((acc && pwrite && paddr == `SFS_DATA_OFF) || !rxd) touched <= 1'b1;
        end
    end

    // Counts down one ten-bit frame from each start edge, with two cycles of slack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_cnt <= 0;
            txd_q <= 1'b1;
        end else begin
            txd_q <= txd_out;
            if (frm_cnt == 0 && txd_oe && txd_q && !txd_out) frm_cnt <= 160 * (int'(baud_m) + 1) - 2;
            else if (frm_cnt != 0 && ce) frm_cnt <= frm_cnt - 1;
        end
    end

    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_unmapped_err: assert property (acc && paddr[1:0] == 2'b00 |-> pslverr == (paddr > `SFS_BAUD_OFF))
        else $error("pslverr wrong for address");
    a_reset_idle: assert property ($rose(presetn) |-> txd_out && !txd_oe && !sci_irq)
        else $error("pin or irq not idle after reset");
    a_status_reset: assert property (stat_rd && !touched |-> prdata[7:0] == 8'h03)
        else $error("status wrong before any traffic");
    a_irq_empty: assert property (stat_rd && prdata[`SFS_S_TX_HOLD_EMPTY_FLAG] && ctrl_m[`SFS_C_TIE] |-> ##[0:1] sci_irq)
        else $error("no irq for empty holding flag");
    a_irq_done: assert property (stat_rd && prdata[`SFS_S_TC] && ctrl_m[`SFS_C_TX_DONE_IRQ_MASK] |-> ##[0:1] sci_irq)
        else $error("no irq for done flag");
    a_irq_masked: assert property ((ctrl_m[5:2] == 4'h0) [*3] |-> !sci_irq)
        else $error("irq with all enables clear");
    a_frame_hold: assert property (frm_cnt != 0 |-> txd_oe)
        else $error("pin released inside a frame");
    a_idle_release: assert property ($fell(ctrl_m[`SFS_C_TXON]) && frm_cnt == 0 |-> ##[0:60] (!txd_oe || !txd_out))
        else $error("pin kept after idle disable");
endmodule

bind sfs_sci sfs_sci_monitor #(.ADDR_W(ADDR_W)) sfs_sci_monitor_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .sci_irq(sci_irq));

/* bench/sfs_remote.sv */
module sfs_remote #(
    parameter int BIT_CYC = 16
) (
    input wire logic pclk,
    output logic rxd,
    input wire logic txd_out,
    input wire logic txd_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_char = 8'h00;
    int got_count = 0;

    initial rxd = 1'b1;

    // A bad stop bit is sent only when the caller asks for it
    task automatic send_char(input logic [7:0] c, input logic stop_ok);
        logic [9:0] frm;
        frm = {stop_ok, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= frm[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
        // One idle cycle so back-to-back frames never drive rxd twice in one step
        rxd <= 1'b1;
        @(posedge pclk);
    endtask

    // Samples mid-bit; the pin only counts while the block owns it
    initial forever begin
        @(posedge pclk);
        if (txd_oe === 1'b1 && txd_out === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge pclk);
                last_char[i] = txd_out;
            end
            repeat (BIT_CYC) @(posedge pclk);
            got_count++;
        end
    end
endmodule

/* bench/sfs_sci_tb.sv */
`include "sfs_defs.svh"

module sfs_sci_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd_out;
    logic txd_oe;
    logic sci_irq;
    logic [31:0] rd;
    logic err;
    int err_count = 0;
    int n_checks = 0;

    always #5 pclk = ~pclk;

    sfs_sci sfs_sci_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .sci_irq(sci_irq));
    sfs_remote #(.BIT_CYC(16)) sfs_remote_inst (.pclk(pclk), .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        if (n >= 40) err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(what, exp, rd & m);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic wait_rx(input int k);
        int n;
        n = 0;
        while (sfs_remote_inst.got_count < k && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) err_count++;
    endtask

    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        idle(10);
        presetn <= 1'b1;
        rd_chk("status", `SFS_STAT_OFF, 32'hFFFFFFFF, 32'h00000003);
        rd_chk("control", `SFS_CTRL_OFF, 32'hFFFFFFFF, 32'h00000000);
        apb(1'b0, 12'h010, 32'h00000000);
        chk("unmapped", 32'h00000001, {31'h0, err});
        // Fastest divisor keeps a frame at 160 cycles
        apb(1'b1, `SFS_BAUD_OFF, 32'h00000000);
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000005);
        rd_chk("enabled flags", `SFS_STAT_OFF, 32'h00000003, 32'h00000003);
        idle(2);
        chk("empty irq", 32'h00000001, {31'h0, sci_irq});
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000009);
        rd_chk("done flag", `SFS_STAT_OFF, 32'h00000002, 32'h00000002);
        idle(2);
        chk("done irq", 32'h00000001, {31'h0, sci_irq});
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000001);
        idle(2);
        chk("masked irq", 32'h00000000, {31'h0, sci_irq});
        apb(1'b1, `SFS_DATA_OFF, 32'h0000005A);
        apb(1'b1, `SFS_DATA_OFF, 32'h000000C3);
        rd_chk("queue full", `SFS_STAT_OFF, 32'h00000003, 32'h00000000);
        wait_rx(1);
        chk("char one", 32'h0000005A, {24'h0, sfs_remote_inst.last_char});
        wait_rx(2);
        chk("char two", 32'h000000C3, {24'h0, sfs_remote_inst.last_char});
        idle(40);
        rd_chk("drained", `SFS_STAT_OFF, 32'h00000003, 32'h00000003);
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000000);
        idle(4);
        chk("idle release", 32'h00000000, {31'h0, txd_oe});
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000001);
        apb(1'b1, `SFS_DATA_OFF, 32'h00000011);
        apb(1'b1, `SFS_DATA_OFF, 32'h00000022);
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000000);
        chk("pin held", 32'h00000001, {31'h0, txd_oe});
        wait_rx(3);
        chk("last char", 32'h00000011, {24'h0, sfs_remote_inst.last_char});
        idle(400);
        chk("queue dropped", 32'h00000003, sfs_remote_inst.got_count);
        rd_chk("flags set", `SFS_STAT_OFF, 32'h00000003, 32'h00000003);
        chk("pin free", 32'h00000000, {31'h0, txd_oe});
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000032);
        sfs_remote_inst.send_char(8'hA5, 1'b1);
        idle(400);
        chk("rx irq", 32'h00000001, {31'h0, sci_irq});
        rd_chk("full idle", `SFS_STAT_OFF, 32'h0000007C, 32'h0000000C);
        rd_chk("rx char", `SFS_DATA_OFF, 32'h000000FF, 32'h000000A5);
        rd_chk("cleared", `SFS_STAT_OFF, 32'h0000007C, 32'h00000000);
        chk("irq off", 32'h00000000, {31'h0, sci_irq});
        idle(400);
        rd_chk("idle once", `SFS_STAT_OFF, 32'h0000007C, 32'h00000000);
        sfs_remote_inst.send_char(8'h3C, 1'b1);
        sfs_remote_inst.send_char(8'h7E, 1'b1);
        idle(40);
        rd_chk("overrun", `SFS_STAT_OFF, 32'h00000014, 32'h00000014);
        rd_chk("old kept", `SFS_DATA_OFF, 32'h000000FF, 32'h0000003C);
        sfs_remote_inst.send_char(8'h81, 1'b0);
        idle(40);
        rd_chk("framing", `SFS_STAT_OFF, 32'h00000040, 32'h00000040);
        // Break holds the idle transmitter low while it owns the pin
        apb(1'b1, `SFS_CTRL_OFF, 32'h00000041);
        idle(2);
        chk("break", 32'h00000000, {31'h0, txd_out});
        tally_and_finish();
    end
endmodule
